// >>> rsfo_top.v
// Radio exit-state, calibration and frequency offset configuration bank with AXI4-Lite slave
// Assumes one 200 MHz clock and radio status inputs synchronous to it
`timescale 1ns/1ps
`default_nettype none
`include "rsfo_defines.vh"
// Function
// - Clear channel flag follows select field
// - After receive, go to selected state
// - After transmit, go to selected state
// - Code 00: calibrate only on strobe
// - Code 01: calibrate leaving idle
// - Code 10: calibrate on automatic idle return
// - Code 11: calibrate every fourth return
// - Gate freezes loops until carrier sense
// - Pre-sync gain K to 4K
// - Post-sync gain pre or K/2
// - Saturation limit none, eighth, quarter, half
module rsfo_top #(
  parameter ADDR_W = 20
) (
  input  wire              mclk_in,
  input  wire              srst_in,
  input  wire [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire              s_axi_awvalid_in,
  output reg               s_axi_awready_out,
  input  wire [31:0]       s_axi_wdata_in,
  input  wire [3:0]        s_axi_wstrb_in,
  input  wire              s_axi_wvalid_in,
  output reg               s_axi_wready_out,
  output reg  [1:0]        s_axi_bresp_out,
  output reg               s_axi_bvalid_out,
  input  wire              s_axi_bready_in,
  input  wire [ADDR_W-1:0] s_axi_araddr_in,
  input  wire              s_axi_arvalid_in,
  output reg               s_axi_arready_out,
  output reg  [31:0]       s_axi_rdata_out,
  output reg  [1:0]        s_axi_rresp_out,
  output reg               s_axi_rvalid_out,
  input  wire              s_axi_rready_in,
  input  wire              rx_done_in,
  input  wire              tx_done_in,
  input  wire              rssi_below_in,
  input  wire              receiving_in,
  input  wire              carrier_sense_in,
  input  wire              sync_found_in,
  input  wire              demod_restart_in,
  output wire [1:0]        radio_state_out,
  output wire              synth_cal_out,
  output wire              preamble_restart_out,
  output wire              clear_channel_flag_out,
  output wire              loop_freeze_gate_out,
  output wire [3:0]        loop_gain_out,
  output wire [1:0]        offset_saturation_limit_out,
  output wire              offset_comp_en_out
);
  // ==========================================================
  // Register storage
  reg  [7:0]        exit_cfg_reg;
  reg  [7:0]        cal_cfg_reg;
  reg  [7:0]        foc_cfg_reg;
  reg  [4:0]        cmd_reg;
  reg  [ADDR_W-1:0] awaddr_reg;
  reg  [7:0]        wdata_reg;
  reg               wstrb_reg;
  reg               aw_held_reg;
  reg               w_held_reg;
  wire [1:0]        cal_count;
  wire              do_write;
  wire [ADDR_W-1:0] a_exit;
  wire [ADDR_W-1:0] a_cal;
  wire [ADDR_W-1:0] a_foc;
  wire [ADDR_W-1:0] a_stat;
  wire [ADDR_W-1:0] a_cmd;

  assign a_exit   = `RSFO_ADDR_EXIT;
  assign a_cal    = `RSFO_ADDR_CAL;
  assign a_foc    = `RSFO_ADDR_FOC;
  assign a_stat   = `RSFO_ADDR_STATUS;
  assign a_cmd    = `RSFO_ADDR_CMD;
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid_out;

  // ==========================================================
  // Address decode
  function rsfo_mapped;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] e;
    input [ADDR_W-1:0] c;
    input [ADDR_W-1:0] f;
    input [ADDR_W-1:0] s;
    input [ADDR_W-1:0] m;
    begin
      rsfo_mapped = (addr == e) | (addr == c) | (addr == f) | (addr == s) | (addr == m);
    end
  endfunction

  // ==========================================================
  // Write channels
  always @(posedge mclk_in) begin
    if (srst_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `RSFO_RESP_OKAY;
      aw_held_reg       <= 1'b0;
      w_held_reg        <= 1'b0;
      awaddr_reg        <= {ADDR_W{1'b0}};
      wdata_reg         <= 8'h00;
      wstrb_reg         <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        awaddr_reg        <= s_axi_awaddr_in;
        aw_held_reg       <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        wdata_reg        <= s_axi_wdata_in[7:0];
        wstrb_reg        <= s_axi_wstrb_in[0];
        w_held_reg       <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg      <= 1'b0;
        w_held_reg       <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        if (rsfo_mapped(awaddr_reg, a_exit, a_cal, a_foc, a_stat, a_cmd)) begin
          s_axi_bresp_out <= `RSFO_RESP_OKAY;
        end else begin
          s_axi_bresp_out <= `RSFO_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Configuration registers and command strobes
  always @(posedge mclk_in) begin
    if (srst_in) begin
      exit_cfg_reg <= `RSFO_RST_EXIT;
      cal_cfg_reg  <= `RSFO_RST_CAL;
      foc_cfg_reg  <= `RSFO_RST_FOC;
      cmd_reg      <= 5'h00;
    end else begin
      cmd_reg <= 5'h00;
      if (do_write && wstrb_reg) begin
        if (awaddr_reg == a_exit) begin
          exit_cfg_reg <= wdata_reg & `RSFO_MASK_EXIT;
        end
        if (awaddr_reg == a_cal) begin
          cal_cfg_reg <= wdata_reg & `RSFO_MASK_CAL;
        end
        if (awaddr_reg == a_foc) begin
          foc_cfg_reg <= wdata_reg & `RSFO_MASK_FOC;
        end
        if (awaddr_reg == a_cmd) begin
          cmd_reg <= wdata_reg[4:0];
        end
      end
    end
  end

  // ==========================================================
  // Read channel
  always @(posedge mclk_in) begin
    if (srst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `RSFO_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rresp_out   <= `RSFO_RESP_OKAY;
        s_axi_rdata_out   <= 32'h00000000;
        if (s_axi_araddr_in == a_exit) begin
          s_axi_rdata_out <= {24'h000000, exit_cfg_reg};
        end else if (s_axi_araddr_in == a_cal) begin
          s_axi_rdata_out <= {24'h000000, cal_cfg_reg};
        end else if (s_axi_araddr_in == a_foc) begin
          s_axi_rdata_out <= {24'h000000, foc_cfg_reg};
        end else if (s_axi_araddr_in == a_stat) begin
          s_axi_rdata_out <= {25'h0000000, cal_count, loop_freeze_gate_out,
                              clear_channel_flag_out, 1'b0, radio_state_out};
        end else if (s_axi_araddr_in != a_cmd) begin
          s_axi_rresp_out <= `RSFO_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Radio state machine
  rsfo_radio_fsm u_fsm (
    .mclk_in       (mclk_in),
    .srst_in       (srst_in),
    .cca_sel_in    (exit_cfg_reg[`RSFO_CCA_HI:`RSFO_CCA_LO]),
    .rx_exit_in    (exit_cfg_reg[`RSFO_RXOFF_HI:`RSFO_RXOFF_LO]),
    .tx_exit_in    (exit_cfg_reg[`RSFO_TXOFF_HI:`RSFO_TXOFF_LO]),
    .autocal_in    (cal_cfg_reg[`RSFO_AUTOCAL_HI:`RSFO_AUTOCAL_LO]),
    .cmd_in        (cmd_reg),
    .rx_done_in    (rx_done_in),
    .tx_done_in    (tx_done_in),
    .rssi_below_in (rssi_below_in),
    .receiving_in  (receiving_in),
    .state_out     (radio_state_out),
    .cal_out       (synth_cal_out),
    .preamble_out  (preamble_restart_out),
    .cca_out       (clear_channel_flag_out),
    .cal_count_out (cal_count)
  );

  // ==========================================================
  // Frequency offset compensation control
  rsfo_foc_ctrl u_foc (
    .mclk_in          (mclk_in),
    .srst_in          (srst_in),
    .gate_in          (foc_cfg_reg[`RSFO_GATE_BIT]),
    .prek_in          (foc_cfg_reg[`RSFO_PREK_HI:`RSFO_PREK_LO]),
    .postk_in         (foc_cfg_reg[`RSFO_POSTK_BIT]),
    .limit_in         (foc_cfg_reg[`RSFO_LIMIT_HI:`RSFO_LIMIT_LO]),
    .carrier_sense_in (carrier_sense_in),
    .sync_found_in    (sync_found_in),
    .restart_in       (demod_restart_in),
    .freeze_out       (loop_freeze_gate_out),
    .gain_out         (loop_gain_out),
    .limit_out        (offset_saturation_limit_out),
    .comp_en_out      (offset_comp_en_out)
  );
endmodule
`default_nettype wire

// >>> rsfo_defines.vh
// Register map, field positions, reset values and codes of the radio configuration bank
// Assumes inclusion by bare name from every design file of the bank
`ifndef RSFO_DEFINES_VH
`define RSFO_DEFINES_VH
// ==========================================================
// Register indices and byte addresses (byte address = 4 * index)
`define RSFO_IDX_EXIT         20'hDF13
`define RSFO_IDX_CAL          20'hDF14
`define RSFO_IDX_FOC          20'hDF15
`define RSFO_IDX_STATUS       20'hDF00
`define RSFO_IDX_CMD          20'hDF01
`define RSFO_ADDR_EXIT        20'h37C4C
`define RSFO_ADDR_CAL         20'h37C50
`define RSFO_ADDR_FOC         20'h37C54
`define RSFO_ADDR_STATUS      20'h37C00
`define RSFO_ADDR_CMD         20'h37C04
// ==========================================================
// Reset values and writable masks
`define RSFO_RST_EXIT         8'h30
`define RSFO_RST_CAL          8'h04
`define RSFO_RST_FOC          8'h76
`define RSFO_MASK_EXIT        8'h3F
`define RSFO_MASK_CAL         8'h3F
`define RSFO_MASK_FOC         8'h7F
// ==========================================================
// Field positions
`define RSFO_CCA_HI           5
`define RSFO_CCA_LO           4
`define RSFO_RXOFF_HI         3
`define RSFO_RXOFF_LO         2
`define RSFO_TXOFF_HI         1
`define RSFO_TXOFF_LO         0
`define RSFO_AUTOCAL_HI       5
`define RSFO_AUTOCAL_LO       4
`define RSFO_GATE_BIT         5
`define RSFO_PREK_HI          4
`define RSFO_PREK_LO          3
`define RSFO_POSTK_BIT        2
`define RSFO_LIMIT_HI         1
`define RSFO_LIMIT_LO         0
`define RSFO_CMD_IDLE         0
`define RSFO_CMD_RX           1
`define RSFO_CMD_TX           2
`define RSFO_CMD_SYNTH_ON_TX_READY       3
`define RSFO_CMD_CAL          4
// ==========================================================
// Radio states and field codes
`define RSFO_ST_IDLE          2'h0
`define RSFO_ST_RX            2'h1
`define RSFO_ST_TX            2'h2
`define RSFO_ST_SYNTH_ON_TX_READY        2'h3
`define RSFO_EXIT_IDLE        2'h0
`define RSFO_EXIT_SYNTH_ON_TX_READY      2'h1
`define RSFO_RXEXIT_TX        2'h2
`define RSFO_RXEXIT_RX        2'h3
`define RSFO_TXEXIT_TX        2'h2
`define RSFO_TXEXIT_RX        2'h3
`define RSFO_CCA_ALWAYS       2'h0
`define RSFO_CCA_RSSI         2'h1
`define RSFO_CCA_NOPKT        2'h2
`define RSFO_CCA_BOTH         2'h3
`define RSFO_CAL_NEVER        2'h0
`define RSFO_CAL_FROM_IDLE    2'h1
`define RSFO_CAL_TO_IDLE      2'h2
`define RSFO_CAL_FOURTH       2'h3
`define RSFO_CAL_COUNT_LAST   2'h3
`define RSFO_RESP_OKAY        2'h0
`define RSFO_RESP_SLVERR      2'h2
`endif

// >>> rsfo_radio_fsm.v
// Radio control state machine: exit states, clear channel flag, synthesizer calibration
// Assumes command and packet-done inputs are one-cycle pulses synchronous to mclk_in
`timescale 1ns/1ps
`default_nettype none
`include "rsfo_defines.vh"
module rsfo_radio_fsm (
  input  wire       mclk_in,
  input  wire       srst_in,
  input  wire [1:0] cca_sel_in,
  input  wire [1:0] rx_exit_in,
  input  wire [1:0] tx_exit_in,
  input  wire [1:0] autocal_in,
  input  wire [4:0] cmd_in,
  input  wire       rx_done_in,
  input  wire       tx_done_in,
  input  wire       rssi_below_in,
  input  wire       receiving_in,
  output reg  [1:0] state_out,
  output reg        cal_out,
  output reg        preamble_out,
  output reg        cca_out,
  output reg  [1:0] cal_count_out
);
  reg [1:0] state_next;
  reg       auto_idle;
  reg       from_idle;
  // ==========================================================
  // Next state
  always @* begin
    state_next = state_out;
    auto_idle  = 1'b0;
    if (cmd_in[`RSFO_CMD_IDLE]) begin
      state_next = `RSFO_ST_IDLE;
    end else if (cmd_in[`RSFO_CMD_RX]) begin
      state_next = `RSFO_ST_RX;
    end else if (cmd_in[`RSFO_CMD_TX]) begin
      state_next = `RSFO_ST_TX;
    end else if (cmd_in[`RSFO_CMD_SYNTH_ON_TX_READY]) begin
      state_next = `RSFO_ST_SYNTH_ON_TX_READY;
    end else if (rx_done_in && state_out == `RSFO_ST_RX) begin
      case (rx_exit_in)
        `RSFO_EXIT_IDLE:   state_next = `RSFO_ST_IDLE;
        `RSFO_EXIT_SYNTH_ON_TX_READY: state_next = `RSFO_ST_SYNTH_ON_TX_READY;
        `RSFO_RXEXIT_TX:   state_next = `RSFO_ST_TX;
        default:           state_next = `RSFO_ST_RX;
      endcase
      auto_idle = (rx_exit_in == `RSFO_EXIT_IDLE);
    end else if (tx_done_in && state_out == `RSFO_ST_TX) begin
      case (tx_exit_in)
        `RSFO_EXIT_IDLE:   state_next = `RSFO_ST_IDLE;
        `RSFO_EXIT_SYNTH_ON_TX_READY: state_next = `RSFO_ST_SYNTH_ON_TX_READY;
        `RSFO_TXEXIT_TX:   state_next = `RSFO_ST_TX;
        default:           state_next = `RSFO_ST_RX;
      endcase
      auto_idle = (tx_exit_in == `RSFO_EXIT_IDLE);
    end
    from_idle = (state_out == `RSFO_ST_IDLE) && (state_next != `RSFO_ST_IDLE);
  end
  // ==========================================================
  // State, calibration and clear channel registers
  always @(posedge mclk_in) begin
    if (srst_in) begin
      state_out     <= `RSFO_ST_IDLE;
      cal_out       <= 1'b0;
      preamble_out  <= 1'b0;
      cca_out       <= 1'b0;
      cal_count_out <= 2'h0;
    end else begin
      state_out    <= state_next;
      preamble_out <= tx_done_in && state_out == `RSFO_ST_TX && tx_exit_in == `RSFO_TXEXIT_TX && cmd_in[3:0] == 4'h0;
      case (autocal_in)
        `RSFO_CAL_FROM_IDLE: cal_out <= from_idle;
        `RSFO_CAL_TO_IDLE:   cal_out <= auto_idle;
        `RSFO_CAL_FOURTH:    cal_out <= auto_idle && cal_count_out == `RSFO_CAL_COUNT_LAST;
        default:             cal_out <= cmd_in[`RSFO_CMD_CAL] && state_out == `RSFO_ST_IDLE;
      endcase
      if (autocal_in != `RSFO_CAL_NEVER && cmd_in[`RSFO_CMD_CAL] && state_out == `RSFO_ST_IDLE) begin
        cal_out <= 1'b1;
      end
      if (autocal_in == `RSFO_CAL_FOURTH && auto_idle) begin
        cal_count_out <= cal_count_out + 2'h1;
      end
      case (cca_sel_in)
        `RSFO_CCA_ALWAYS: cca_out <= 1'b1;
        `RSFO_CCA_RSSI:   cca_out <= rssi_below_in;
        `RSFO_CCA_NOPKT:  cca_out <= ~receiving_in;
        default:          cca_out <= rssi_below_in & ~receiving_in;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> rsfo_foc_ctrl.v
// Frequency offset compensation control: loop freeze, loop gain, saturation limit
// Assumes carrier sense, sync detect and restart inputs synchronous to mclk_in
`timescale 1ns/1ps
`default_nettype none
`include "rsfo_defines.vh"
module rsfo_foc_ctrl (
  input  wire       mclk_in,
  input  wire       srst_in,
  input  wire       gate_in,
  input  wire [1:0] prek_in,
  input  wire       postk_in,
  input  wire [1:0] limit_in,
  input  wire       carrier_sense_in,
  input  wire       sync_found_in,
  input  wire       restart_in,
  output reg        freeze_out,
  output reg  [3:0] gain_out,
  output reg  [1:0] limit_out,
  output reg        comp_en_out
);
  reg cs_seen_reg;
  // ==========================================================
  // Gain in units of K/2
  function [3:0] rsfo_pre_gain;
    input [1:0] code;
    begin
      rsfo_pre_gain = {1'b0, code, 1'b0} + 4'h2;
    end
  endfunction
  // ==========================================================
  // Freeze, gain and limit registers
  always @(posedge mclk_in) begin
    if (srst_in) begin
      cs_seen_reg <= 1'b0;
      freeze_out  <= 1'b1;
      gain_out    <= 4'h2;
      limit_out   <= 2'h0;
      comp_en_out <= 1'b0;
    end else begin
      if (carrier_sense_in) begin
        cs_seen_reg <= 1'b1;
      end else if (restart_in) begin
        cs_seen_reg <= 1'b0;
      end
      freeze_out <= gate_in & ~carrier_sense_in & (restart_in | ~cs_seen_reg);
      if (sync_found_in && postk_in) begin
        gain_out <= 4'h1;
      end else begin
        gain_out <= rsfo_pre_gain(prek_in);
      end
      limit_out   <= limit_in;
      comp_en_out <= (limit_in != 2'h0);
    end
  end
endmodule
`default_nettype wire

// >>> rsfo_top_assertions.sv
// Checker of the configuration bank port behaviour
// Assumes binding into rsfo_top, one clock, synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module rsfo_top_checker (
  input wire logic        mclk_in,
  input wire logic        srst_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        rssi_below_in,
  input wire logic        receiving_in,
  input wire logic        carrier_sense_in,
  input wire logic        sync_found_in,
  input wire logic [1:0]  radio_state_out,
  input wire logic        synth_cal_out,
  input wire logic        preamble_restart_out,
  input wire logic        clear_channel_flag_out,
  input wire logic        loop_freeze_gate_out,
  input wire logic [3:0]  loop_gain_out,
  input wire logic [1:0]  offset_saturation_limit_out,
  input wire logic        offset_comp_en_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // ==========================================================
  // Bus behaviour
  write_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out) else $error("write response missing");
  bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read response missing");
  rdata_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  rdata_upper_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000)
    else $error("upper read bits set");
  // ==========================================================
  // Radio and demodulator behaviour
  clear_flag_a: assert property (rssi_below_in && !receiving_in |=> clear_channel_flag_out)
    else $error("clear channel flag low");
  freeze_release_a: assert property (carrier_sense_in |=> !loop_freeze_gate_out)
    else $error("loops still frozen");
  presync_gain_a: assert property (!sync_found_in |=> loop_gain_out inside {4'h2, 4'h4, 4'h6, 4'h8})
    else $error("bad pre-sync gain");
  limit_enable_a: assert property (offset_comp_en_out == (offset_saturation_limit_out != 2'h0))
    else $error("compensation enable wrong");
  preamble_tx_a: assert property (preamble_restart_out |-> radio_state_out == 2'h2)
    else $error("preamble restart outside transmit");
  cover property (s_axi_bvalid_out && s_axi_bready_in);
  cover property (synth_cal_out);
  cover property (preamble_restart_out);
endmodule

bind rsfo_top rsfo_top_checker u_chk (.*);
`default_nettype wire

// >>> rsfo_top_tb.sv
// Self-checking bench of the radio configuration bank
// Assumes rsfo_top and its checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "rsfo_defines.vh"
module rsfo_top_tb;
  logic        mclk_in, srst_in;
  logic [19:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in;
  logic [3:0]  s_axi_wstrb_in;
  logic        s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
  logic        rx_done_in, tx_done_in, rssi_below_in, receiving_in;
  logic        carrier_sense_in, sync_found_in, demod_restart_in;
  wire         s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  wire [1:0]   s_axi_bresp_out, s_axi_rresp_out, radio_state_out, offset_saturation_limit_out;
  wire [31:0]  s_axi_rdata_out;
  wire         synth_cal_out, preamble_restart_out, clear_channel_flag_out;
  wire         loop_freeze_gate_out, offset_comp_en_out;
  wire [3:0]   loop_gain_out;
  integer      err_count = 0, compares = 0, cycles = 0, cal_n = 0, pre_n = 0, i, k, n;

  rsfo_top #(.ADDR_W(20)) DUT (.*);

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (synth_cal_out === 1'b1) cal_n <= cal_n + 1;
    if (preamble_restart_out === 1'b1) pre_n <= pre_n + 1;
    if (cycles == 30000) begin
      err_count = err_count + 1;
      close_out;
    end
  end
  // ==========================================================
  // Common tasks
  task close_out;
    begin
      $display("Counts: %0d compares, %0d errors", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task axi_write(input [19:0] a, input [7:0] d, input bad);
    begin
      @(posedge mclk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= {24'h000000, d};
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      do begin
        @(posedge mclk_in);
        if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
        if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end while (s_axi_bvalid_out !== 1'b1);
      s_axi_bready_in <= 1'b0;
      chk(s_axi_bresp_out, bad ? `RSFO_RESP_SLVERR : `RSFO_RESP_OKAY);
    end
  endtask

  task axi_read(input [19:0] a, input [31:0] ed, input bad);
    begin
      @(posedge mclk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      do begin
        @(posedge mclk_in);
        if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      end while (s_axi_rvalid_out !== 1'b1);
      s_axi_rready_in <= 1'b0;
      chk(s_axi_rdata_out, ed);
      chk(s_axi_rresp_out, bad ? `RSFO_RESP_SLVERR : `RSFO_RESP_OKAY);
    end
  endtask

  task cmd(input integer b);
    begin
      axi_write(`RSFO_ADDR_CMD, 8'h01 << b, 1'b0);
      repeat (3) @(posedge mclk_in);
    end
  endtask

  task done_pulse(input tx);
    begin
      @(posedge mclk_in);
      if (tx) tx_done_in <= 1'b1;
      else rx_done_in <= 1'b1;
      @(posedge mclk_in);
      tx_done_in <= 1'b0;
      rx_done_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
    end
  endtask

  task restart_pulse;
    begin
      @(posedge mclk_in);
      demod_restart_in <= 1'b1;
      @(posedge mclk_in);
      demod_restart_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
    end
  endtask

  task do_reset;
    begin
      @(posedge mclk_in);
      srst_in <= 1'b1;
      repeat (6) @(posedge mclk_in);
      srst_in <= 1'b0;
      @(posedge mclk_in);
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    begin
      axi_read(`RSFO_ADDR_EXIT, `RSFO_RST_EXIT, 1'b0);
      axi_read(`RSFO_ADDR_CAL, `RSFO_RST_CAL, 1'b0);
      axi_read(`RSFO_ADDR_FOC, `RSFO_RST_FOC, 1'b0);
      chk(loop_gain_out, 32'h6);
      chk(offset_saturation_limit_out, 32'h2);
      $display("test reset done");
    end
  endtask

  task t_mask;
    begin
      axi_write(`RSFO_ADDR_EXIT, 8'hFF, 1'b0);
      axi_read(`RSFO_ADDR_EXIT, `RSFO_MASK_EXIT, 1'b0);
      axi_write(`RSFO_ADDR_CAL, 8'hFF, 1'b0);
      axi_read(`RSFO_ADDR_CAL, `RSFO_MASK_CAL, 1'b0);
      axi_write(`RSFO_ADDR_FOC, 8'hFF, 1'b0);
      axi_read(`RSFO_ADDR_FOC, `RSFO_MASK_FOC, 1'b0);
      axi_write(20'h00010, 8'h12, 1'b1);
      axi_read(20'h00010, 32'h0, 1'b1);
      axi_write(`RSFO_ADDR_EXIT, 8'h30, 1'b0);
      axi_write(`RSFO_ADDR_CAL, 8'h04, 1'b0);
      axi_write(`RSFO_ADDR_FOC, 8'h36, 1'b0);
      $display("test mask done");
    end
  endtask

  task t_cca;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        axi_write(`RSFO_ADDR_EXIT, {2'h0, k[1:0], 4'h0}, 1'b0);
        for (i = 0; i < 4; i = i + 1) begin
          @(posedge mclk_in);
          rssi_below_in <= i[0];
          receiving_in <= i[1];
          repeat (3) @(posedge mclk_in);
          chk(clear_channel_flag_out, (k == 0) | (k == 1 & i[0]) | (k == 2 & !i[1]) | (k == 3 & i[0] & !i[1]));
        end
      end
      $display("test clear channel done");
    end
  endtask

  task t_exit(input tx);
    begin
      for (k = 0; k < 4; k = k + 1) begin
        axi_write(`RSFO_ADDR_EXIT, tx ? {6'h0, k[1:0]} : {4'h0, k[1:0], 2'h0}, 1'b0);
        cmd(`RSFO_CMD_IDLE);
        cmd(tx ? `RSFO_CMD_TX : `RSFO_CMD_RX);
        n = pre_n;
        done_pulse(tx);
        chk(radio_state_out, (k == 1) ? 3 : (k == 3) ? 1 : k);
        if (tx) chk(pre_n - n, k == 2);
      end
      cmd(`RSFO_CMD_IDLE);
      $display("test exit state done");
    end
  endtask

  task t_cal;
    begin
      axi_write(`RSFO_ADDR_EXIT, 8'h00, 1'b0);
      n = cal_n;
      cmd(`RSFO_CMD_RX);
      chk(cal_n - n, 0);
      cmd(`RSFO_CMD_IDLE);
      cmd(`RSFO_CMD_CAL);
      chk(cal_n - n, 1);
      axi_write(`RSFO_ADDR_CAL, 8'h14, 1'b0);
      cmd(`RSFO_CMD_RX);
      chk(cal_n - n, 2);
      done_pulse(1'b0);
      chk(cal_n - n, 2);
      cmd(`RSFO_CMD_SYNTH_ON_TX_READY);
      axi_read(`RSFO_ADDR_STATUS, 32'h1B, 1'b0);
      chk(cal_n - n, 3);
      cmd(`RSFO_CMD_IDLE);
      axi_write(`RSFO_ADDR_CAL, 8'h24, 1'b0);
      cmd(`RSFO_CMD_RX);
      done_pulse(1'b0);
      chk(cal_n - n, 4);
      do_reset;
      axi_write(`RSFO_ADDR_CAL, 8'h34, 1'b0);
      n = cal_n;
      for (k = 0; k < 4; k = k + 1) begin
        cmd(`RSFO_CMD_RX);
        done_pulse(1'b0);
        chk(cal_n - n, k == 3);
      end
      $display("test calibration done");
    end
  endtask

  task t_foc;
    begin
      axi_write(`RSFO_ADDR_FOC, 8'h20, 1'b0);
      restart_pulse;
      chk(loop_freeze_gate_out, 1);
      carrier_sense_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      chk(loop_freeze_gate_out, 0);
      carrier_sense_in <= 1'b0;
      axi_write(`RSFO_ADDR_FOC, 8'h00, 1'b0);
      restart_pulse;
      chk(loop_freeze_gate_out, 0);
      for (k = 0; k < 4; k = k + 1) begin
        axi_write(`RSFO_ADDR_FOC, {3'h0, k[1:0], 1'b1, k[1:0]}, 1'b0);
        repeat (3) @(posedge mclk_in);
        chk(loop_gain_out, 2 * k + 2);
        chk(offset_saturation_limit_out, k);
        chk(offset_comp_en_out, k != 0);
        sync_found_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        chk(loop_gain_out, 1);
        axi_write(`RSFO_ADDR_FOC, {3'h0, k[1:0], 1'b0, k[1:0]}, 1'b0);
        repeat (3) @(posedge mclk_in);
        chk(loop_gain_out, 2 * k + 2);
        sync_found_in <= 1'b0;
      end
      $display("test offset compensation done");
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    srst_in = 1'b1;
    s_axi_awaddr_in = 20'h00000;
    s_axi_araddr_in = 20'h00000;
    s_axi_wdata_in = 32'h00000000;
    s_axi_wstrb_in = 4'h1;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 5'h00;
    {rx_done_in, tx_done_in, rssi_below_in, receiving_in} = 4'h0;
    {carrier_sense_in, sync_found_in, demod_restart_in} = 3'h0;
    repeat (6) @(posedge mclk_in);
    srst_in <= 1'b0;
    @(posedge mclk_in);
    t_reset;
    t_mask;
    t_cca;
    t_exit(1'b0);
    t_exit(1'b1);
    t_cal;
    t_foc;
    close_out;
  end
endmodule
`default_nettype wire
